// *** rtl/fa_filter_accelerator.sv ***
/*
 * Filter accelerator datapath: pair storage, multiply-accumulate, shift,
 * rounding, alu and hold register, steered by a per-cycle control word.
 * Assumes an external controller sequences the control word and that the
 * system bus (dma or mcu) loads pairs and collects results through the
 * plain strobe ports below.
 */
`timescale 1ns/100ps
module fa_filter_accelerator
   import fa_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // system bus write of samples and coefficients
   input wire logic bus_wr_en,
   input wire logic bus_wr_coef,
   input wire logic [fa_pkg::ADDR_W-1:0] bus_addr,
   input wire logic [fa_pkg::DW-1:0] bus_wdata,
   // system bus collection of results
   input wire logic bus_rd_en,
   output logic [fa_pkg::DW-1:0] result_data,
   output logic result_pending,
   // control word from the filter controller
   input wire logic ctrl_valid,
   input wire logic [fa_pkg::CW-1:0] ctrl_word,
   // datapath status
   output logic flag_gt,
   output logic flag_eq,
   output logic flag_neg,
   output logic flag_sat
);
   import fa_pkg::*;

   logic [CW-1:0] cw1;
   logic [CW-1:0] cw2;
   logic [CW-1:0] next_cw1;
   logic [CW-1:0] next_cw2;
   logic [ACC_W-1:0] acc;
   logic [ACC_W-1:0] next_acc;
   logic [DW-1:0] hold;
   logic [DW-1:0] next_hold;
   logic [DW-1:0] bus_stage;
   logic [DW-1:0] next_bus_stage;
   logic [DW-1:0] sample2;
   logic [DW-1:0] next_sample2;
   logic [DW-1:0] next_result_data;
   logic next_result_pending;
   logic next_flag_gt;
   logic next_flag_eq;
   logic next_flag_neg;
   logic next_flag_sat;
   logic [DW-1:0] sample_rd;
   logic [DW-1:0] coef_rd;
   logic signed [ACC_W-1:0] product;
   logic [DW-1:0] mac_res;
   logic [DW-1:0] rnd_res;
   logic [DW-1:0] op_a;
   logic [DW-1:0] op_b;
   logic [DW:0] sum_x;
   logic [DW:0] dif_x;
   logic [DW-1:0] abs_a;
   logic abs_clip;
   logic [DW-1:0] alu_res;
   logic alu_clip;
   logic signed_gt;
   logic [1:0] mac_f;
   logic [2:0] alu_f;
   logic [1:0] src_f;
   logic [1:0] shf_f;
   logic rnd_f;
   logic [1:0] out_f;

   // sample and coefficient halves of the 64 pair store
   fa_pair_ram #(.WIDTH(DW), .DEPTH(DEPTH), .AW(ADDR_W)) u_sample_ram (
      .clk(clk),
      .wr_en(bus_wr_en && !bus_wr_coef),
      .wr_addr(bus_addr),
      .wr_data(bus_wdata),
      .rd_addr(ctrl_word[F_ADDR +: ADDR_W]),
      .rd_data(sample_rd)
   );
   fa_pair_ram #(.WIDTH(DW), .DEPTH(DEPTH), .AW(ADDR_W)) u_coef_ram (
      .clk(clk),
      .wr_en(bus_wr_en && bus_wr_coef),
      .wr_addr(bus_addr),
      .wr_data(bus_wdata),
      .rd_addr(ctrl_word[F_ADDR +: ADDR_W]),
      .rd_data(coef_rd)
   );

   // control word fields, split at the stage where each acts
   assign mac_f = cw1[F_MAC +: 2];
   assign alu_f = cw2[F_ALU +: 3];
   assign src_f = cw2[F_SRC +: 2];
   assign shf_f = cw2[F_SHF +: 2];
   assign rnd_f = cw2[F_RND];
   assign out_f = cw2[F_OUT +: 2];

   // fractional product: two sign bits, so bits 46:23 keep the point
   assign product = $signed(sample_rd) * $signed(coef_rd);
   assign mac_res = acc[MAC_HI:MAC_LO];

   // rounding from the bit below the slice, never wrapping past the top
   always_comb begin
      if (rnd_f && acc[RND_BIT] && (mac_res != FA_MAX)) begin
         rnd_res = mac_res + 24'h000001;
      end else begin
         rnd_res = mac_res;
      end
   end

   // shifter and second-operand routing
   always_comb begin
      case (fa_shf_e'(shf_f))
         FA_SHF_LEFT1: op_a = {rnd_res[DW-2:0], 1'b0};
         FA_SHF_RIGHT1: op_a = {rnd_res[DW-1], rnd_res[DW-1:1]};
         FA_SHF_RIGHT2: op_a = {{2{rnd_res[DW-1]}}, rnd_res[DW-1:2]};
         default: op_a = rnd_res;
      endcase
      case (fa_src_e'(src_f))
         FA_SRC_HOLD: op_b = hold;
         FA_SRC_BUS: op_b = bus_stage;
         FA_SRC_SAMPLE: op_b = sample2;
         default: op_b = FA_ZERO;
      endcase
   end

   // alu helpers: 25-bit sums expose overflow, abs clips the minimum
   assign sum_x = {op_a[DW-1], op_a} + {op_b[DW-1], op_b};
   assign dif_x = {op_a[DW-1], op_a} - {op_b[DW-1], op_b};
   assign abs_clip = (op_a == FA_MIN);
   assign abs_a = abs_clip ? FA_MAX :
                  (op_a[DW-1] ? FA_ZERO - op_a : op_a);
   assign signed_gt = $signed(op_a) > $signed(op_b);

   // alu operation select
   always_comb begin
      alu_clip = 1'b0;
      case (fa_alu_e'(alu_f))
         FA_ALU_ADD: alu_res = sum_x[DW-1:0];
         FA_ALU_SUB: alu_res = dif_x[DW-1:0];
         FA_ALU_CMP: alu_res = op_a;
         FA_ALU_THR: alu_res = signed_gt ? op_a : FA_ZERO;
         FA_ALU_ABS: begin
            alu_res = abs_a;
            alu_clip = abs_clip;
         end
         FA_ALU_SQL: alu_res = (abs_a < op_b) ? FA_ZERO : op_a;
         FA_ALU_SAT: begin
            // clamp by the true sign when the sum leaves 24 bits
            if (sum_x[DW] != sum_x[DW-1]) begin
               alu_res = sum_x[DW] ? FA_MIN : FA_MAX;
               alu_clip = 1'b1;
            end else begin
               alu_res = sum_x[DW-1:0];
            end
         end
         default: alu_res = op_a;
      endcase
   end

   // next values: control pipe, accumulator, routing registers
   always_comb begin
      next_cw1 = ctrl_valid ? ctrl_word : CW_IDLE;
      next_cw2 = cw1;
      next_sample2 = sample_rd;
      next_bus_stage = bus_wr_en ? bus_wdata : bus_stage;
      case (fa_mac_e'(mac_f))
         FA_MAC_LOAD: next_acc = product;
         FA_MAC_ACC: next_acc = acc + product;
         FA_MAC_CLR: next_acc = ACC_ZERO;
         default: next_acc = acc;
      endcase
      next_hold = out_f[OUT_HOLD] ? alu_res : hold;
   end

   // next values: result port and status flags
   always_comb begin
      next_result_data = result_data;
      next_result_pending = result_pending;
      next_flag_gt = flag_gt;
      next_flag_eq = flag_eq;
      next_flag_neg = flag_neg;
      next_flag_sat = flag_sat;
      if (bus_rd_en) begin
         next_result_pending = 1'b0;
      end
      if (out_f[OUT_BUS]) begin
         next_result_data = alu_res;
         next_result_pending = 1'b1; // set wins over the read clear
      end
      if (cw2 != CW_IDLE) begin
         next_flag_gt = signed_gt;
         next_flag_eq = (op_a == op_b);
         next_flag_neg = alu_res[DW-1];
         next_flag_sat = alu_clip;
      end
   end

   // register every group
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cw1 <= CW_IDLE;
         cw2 <= CW_IDLE;
         acc <= ACC_ZERO;
         hold <= FA_ZERO;
         bus_stage <= FA_ZERO;
         sample2 <= FA_ZERO;
         result_data <= FA_ZERO;
         result_pending <= 1'b0;
         flag_gt <= 1'b0;
         flag_eq <= 1'b0;
         flag_neg <= 1'b0;
         flag_sat <= 1'b0;
      end else begin
         cw1 <= next_cw1;
         cw2 <= next_cw2;
         acc <= next_acc;
         hold <= next_hold;
         bus_stage <= next_bus_stage;
         sample2 <= next_sample2;
         result_data <= next_result_data;
         result_pending <= next_result_pending;
         flag_gt <= next_flag_gt;
         flag_eq <= next_flag_eq;
         flag_neg <= next_flag_neg;
         flag_sat <= next_flag_sat;
      end
   end
endmodule : fa_filter_accelerator

// *** rtl/fa_pkg.sv ***
/*
 * Constants, field layout and operation codes for the filter accelerator.
 * Assumes one clock domain and that every user of the constants imports
 * this package.
 */
// What this block does
// - every cycle, multiply two 24-bit operands; the mac field loads, adds into, holds or clears the 48-bit sum
// - hand the ALU accumulator bits 46 down to 23 as a 24-bit value
// - operands are signed fractions, binary point just after the top bit
// - datapath values are 24 bits; only the accumulator is wider
// - ALU adds, subtracts, compares, thresholds, abs, squelch and saturates
// - an 18-bit control word of seven fields steers the datapath each cycle
// - storage holds 64 sample and coefficient pairs
// - sample and coefficient RAMs plus routing, shift, hold and rounding
// - samples enter and results leave over the system bus, DMA or MCU
package fa_pkg;
   // widths and depth
   localparam int DW = 24;
   localparam int ACC_W = 48;
   localparam int DEPTH = 64;
   localparam int ADDR_W = 6;
   localparam int CW = 18;
   // accumulator slice handed to the alu, and the rounding bit below it
   localparam int MAC_HI = 46;
   localparam int MAC_LO = 23;
   localparam int RND_BIT = 22;
   // control word field positions (low bit of each field)
   localparam int F_MAC = 0;
   localparam int F_ADDR = 2;
   localparam int F_ALU = 8;
   localparam int F_SRC = 11;
   localparam int F_SHF = 13;
   localparam int F_RND = 15;
   localparam int F_OUT = 16;
   // fixed-point limits
   localparam logic [DW-1:0] FA_MAX = 24'h7fffff;
   localparam logic [DW-1:0] FA_MIN = 24'h800000;
   localparam logic [DW-1:0] FA_ZERO = 24'h000000;
   localparam logic [ACC_W-1:0] ACC_ZERO = 48'h000000000000;
   localparam logic [CW-1:0] CW_IDLE = 18'h00000;
   // accumulator action
   typedef enum logic [1:0] {
      FA_MAC_HOLD = 2'h0, FA_MAC_LOAD = 2'h1,
      FA_MAC_ACC = 2'h2, FA_MAC_CLR = 2'h3
   } fa_mac_e;
   // alu operation
   typedef enum logic [2:0] {
      FA_ALU_PASS = 3'h0, FA_ALU_ADD = 3'h1, FA_ALU_SUB = 3'h2,
      FA_ALU_CMP = 3'h3, FA_ALU_THR = 3'h4, FA_ALU_ABS = 3'h5,
      FA_ALU_SQL = 3'h6, FA_ALU_SAT = 3'h7
   } fa_alu_e;
   // alu second operand
   typedef enum logic [1:0] {
      FA_SRC_HOLD = 2'h0, FA_SRC_BUS = 2'h1,
      FA_SRC_SAMPLE = 2'h2, FA_SRC_ZERO = 2'h3
   } fa_src_e;
   // shift applied to the accumulator slice
   typedef enum logic [1:0] {
      FA_SHF_NONE = 2'h0, FA_SHF_LEFT1 = 2'h1,
      FA_SHF_RIGHT1 = 2'h2, FA_SHF_RIGHT2 = 2'h3
   } fa_shf_e;
   // output field bits
   localparam int OUT_HOLD = 0;
   localparam int OUT_BUS = 1;
endpackage : fa_pkg

// *** rtl/fa_pair_ram.sv ***
/*
 * Single-write, single-read storage for one half of the data pairs.
 * Assumes writes and reads share clk; read data is registered, so it
 * appears one edge after the address.
 */
`timescale 1ns/100ps
module fa_pair_ram #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 64,
   parameter int AW = 6
) (
   // clock
   input wire logic clk,
   // write side
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   // read side
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   // write then registered read; a same-address read returns old contents
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule : fa_pair_ram

// *** dv/fa_bus_sink.sv ***
/* bus collector model: reads each pending result.
   assumes clk and rst shared with the accelerator. */
`timescale 1ns/100ps
module fa_bus_sink (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pace and handshake
   input wire logic slow,
   input wire logic result_pending,
   output logic bus_rd_en,
   output logic [15:0] taken
);
   logic [2:0] cnt;
   logic [2:0] next_cnt;
   logic next_rd;
   logic [15:0] next_taken;
   // one read pulse per pending result, slow adds a wait
   always_comb begin
      next_rd = 1'h0;
      next_cnt = cnt;
      next_taken = taken;
      if (result_pending && !bus_rd_en) begin
         if (cnt != 3'h0) begin
            next_cnt = cnt - 3'h1;
         end else begin
            next_rd = 1'h1;
            next_taken = taken + 16'h1;
            next_cnt = {slow, 2'h0};
         end
      end
   end
   // state registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 3'h0;
         bus_rd_en <= 1'h0;
         taken <= 16'h0;
      end else begin
         cnt <= next_cnt;
         bus_rd_en <= next_rd;
         taken <= next_taken;
      end
   end
endmodule : fa_bus_sink

// *** dv/fa_filter_accelerator_monitor.sv ***
/* port checker for the accelerator.
   assumes it is bound to fa_filter_accelerator. */
`timescale 1ns/100ps
module fa_filter_accelerator_monitor
   import fa_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // watched ports
   input wire logic bus_rd_en,
   input wire logic [fa_pkg::DW-1:0] result_data,
   input wire logic result_pending,
   input wire logic ctrl_valid,
   input wire logic [fa_pkg::CW-1:0] ctrl_word,
   input wire logic flag_gt,
   input wire logic flag_eq,
   input wire logic flag_neg,
   input wire logic flag_sat
);
   import fa_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic wr_res;
   logic [2:0] op;
   // fields of the word taken at this edge
   assign wr_res = ctrl_valid && ctrl_word[F_OUT+1];
   assign op = ctrl_word[F_ALU+:3];
   a_pend_set: assert property (wr_res |-> ##3 result_pending)
      else $error("pending not set");
   a_pend_clear: assert property (bus_rd_en && !$past(wr_res, 2)
      |=> !result_pending) else $error("pending not cleared");
   a_data_hold: assert property (!wr_res |-> ##3 $stable(result_data))
      else $error("result changed without write");
   a_flag_hold: assert property (!ctrl_valid
      |-> ##3 $stable({flag_gt, flag_eq, flag_neg, flag_sat}))
      else $error("flags changed on idle");
   a_neg_sign: assert property (wr_res
      |-> ##3 flag_neg == result_data[23]) else $error("sign flag wrong");
   a_gt_eq: assert property (!(flag_gt && flag_eq))
      else $error("gt and eq together");
   a_sat_clamp: assert property (wr_res && op == FA_ALU_SAT
      |-> ##3 (!flag_sat || result_data == FA_MAX || result_data == FA_MIN))
      else $error("clamp value wrong");
   a_abs_pos: assert property (wr_res && op == FA_ALU_ABS
      |-> ##3 !result_data[23]) else $error("abs negative");
   a_clr_zero: assert property (wr_res && op == FA_ALU_PASS
      && ctrl_word[F_MAC+:2] == FA_MAC_CLR |-> ##3 result_data == FA_ZERO)
      else $error("clear not zero");
endmodule : fa_filter_accelerator_monitor
bind fa_filter_accelerator fa_filter_accelerator_monitor i_mon (.clk, .rst,
   .bus_rd_en, .result_data, .result_pending, .ctrl_valid, .ctrl_word,
   .flag_gt, .flag_eq, .flag_neg, .flag_sat);

// *** dv/tb_top.sv ***
/* self-checking bench for the filter accelerator.
   assumes the bus collector model and the bound checker. */
`timescale 1ns/100ps
module tb_top;
   import fa_pkg::*;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic bus_wr_en = 1'h0;
   logic bus_wr_coef = 1'h0;
   logic [5:0] bus_addr = 6'h0;
   logic [23:0] bus_wdata = 24'h0;
   logic ctrl_valid = 1'h0;
   logic [17:0] ctrl_word = 18'h0;
   logic slow = 1'h0;
   logic bus_rd_en, result_pending, flag_gt, flag_eq, flag_neg, flag_sat;
   logic [23:0] result_data;
   logic [15:0] taken;
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int nres = 0;
   logic [23:0] hold_exp = 24'h0;
   // clear the accumulator, then pass its zero slice to the result port
   localparam logic [17:0] W_CLR = {2'h2, 5'h0, FA_ALU_PASS, 6'h0,
      FA_MAC_CLR};
   logic [31:0] seed = 32'h3884;
   logic [23:0] smp [64];
   logic [23:0] cof [64];
   // clock
   always #4 clk = ~clk;
   fa_filter_accelerator i_fa_filter_accelerator (.clk, .rst, .bus_wr_en,
      .bus_wr_coef, .bus_addr, .bus_wdata, .bus_rd_en, .result_data,
      .result_pending, .ctrl_valid, .ctrl_word, .flag_gt, .flag_eq,
      .flag_neg, .flag_sat);
   fa_bus_sink i_fa_bus_sink (.clk, .rst, .slow, .result_pending,
      .bus_rd_en, .taken);
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         wrap_up();
      end
   end
   // random source
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   // operand a as the alu sees it: slice, round, then shift
   function automatic logic signed [23:0] exp_a(logic signed [47:0] acc,
      logic [17:0] w);
      logic signed [23:0] a;
      a = acc[46:23];
      if (w[F_RND] && acc[22] && a != FA_MAX) a = a + 24'h1;
      case (w[F_SHF+:2])
         2'h1: a = a <<< 1;
         2'h2: a = a >>> 1;
         2'h3: a = a >>> 2;
         default: ;
      endcase
      return a;
   endfunction : exp_a
   // expected {sat, result} of a word acting on acc and operand b
   function automatic logic [24:0] exp_alu(logic signed [47:0] acc,
      logic [17:0] w, logic signed [23:0] b);
      logic signed [23:0] a;
      logic signed [24:0] s;
      logic [23:0] m;
      a = exp_a(acc, w);
      s = (a < 0) ? -a : a;
      m = (a == FA_MIN) ? FA_MAX : s[23:0];
      case (w[F_ALU+:3])
         3'h1: return {1'h0, a + b};
         3'h2: return {1'h0, a - b};
         3'h4: return {1'h0, a > b ? a : FA_ZERO};
         3'h5: return {a == FA_MIN, m};
         // squelch takes b as an unsigned magnitude threshold
         3'h6: return {1'h0, m < $unsigned(b) ? FA_ZERO : a};
         3'h7: begin
            s = a + b;
            if (s > 25'sh07fffff) return {1'h1, FA_MAX};
            if (s < -25'sh0800000) return {1'h1, FA_MIN};
            return {1'h0, s[23:0]};
         end
         default: return {1'h0, a};
      endcase
   endfunction : exp_alu
   // compare and count
   task chk(input logic [24:0] got, input logic [24:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one bus write pulse
   task wr(input logic cf, input logic [5:0] a, input logic [23:0] d);
      @(posedge clk);
      bus_wr_en <= 1'h1;
      bus_wr_coef <= cf;
      bus_addr <= a;
      bus_wdata <= d;
      if (cf) cof[a] = d;
      else smp[a] = d;
      @(posedge clk);
      bus_wr_en <= 1'h0;
   endtask : wr
   // two back-to-back words, then wait for the second result
   task run2(input logic [17:0] w1, input logic [17:0] w2);
      @(posedge clk);
      ctrl_valid <= 1'h1;
      ctrl_word <= w1;
      @(posedge clk);
      ctrl_word <= w2;
      @(posedge clk);
      ctrl_valid <= 1'h0;
      ctrl_word <= CW_IDLE;
      repeat (2) @(posedge clk);
      #1;
   endtask : run2
   // closing report
   task wrap_up();
      $display("checks %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up
   // main sequence
   initial begin
      logic [31:0] r;
      logic [5:0] k1, k2;
      logic [23:0] b;
      logic [17:0] w;
      logic signed [47:0] acc;
      logic signed [23:0] a;
      logic [23:0] ob;
      logic [24:0] e;
      logic [1:0] src;
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      run2(CW_IDLE, W_CLR);
      chk({flag_sat, result_data}, 25'h0);
      nres = 1;
      for (int i = 0; i < 48; i++) begin
         r = xs();
         k1 = r[5:0];
         k2 = (i == 2) ? k1 : r[11:6];
         src = (i < 3) ? FA_SRC_BUS : r[18:17];
         w = {1'h1, r[16], r[14:12], src, i[2:0], k2, FA_MAC_ACC};
         slow <= r[15];
         for (int j = 0; j < 4; j++) begin
            r = xs();
            wr(j[0], j < 2 ? k1 : k2,
               i < 2 ? (i == 1 ? FA_MAX : FA_MIN) : r[23:0]);
         end
         // at i == 2 the bus word equals operand a, so eq must rise
         acc = $signed(smp[k1]) * $signed(cof[k1])
            + $signed(smp[k2]) * $signed(cof[k2]);
         r = xs();
         b = i < 2 ? FA_MAX : (i == 2 ? exp_a(acc, w) : r[23:0]);
         wr(1'h0, i == 2 ? k1 ^ 6'h20 : r[29:24], b);
         acc = $signed(smp[k1]) * $signed(cof[k1])
            + $signed(smp[k2]) * $signed(cof[k2]);
         a = exp_a(acc, w);
         // second operand as routed by the source field
         case (src)
            2'h0: ob = hold_exp;
            2'h1: ob = b;
            2'h2: ob = smp[k2];
            default: ob = FA_ZERO;
         endcase
         run2({10'h0, k1, FA_MAC_LOAD}, w);
         e = exp_alu(acc, w, ob);
         chk({flag_sat, result_data}, e);
         chk({22'h0, flag_gt, flag_eq, flag_neg},
            {22'h0, a > $signed(ob), a == ob, e[23]});
         if (w[F_OUT]) hold_exp = e[23:0];
         nres++;
      end
      // clear after nonzero results: result must return to zero
      run2(CW_IDLE, W_CLR);
      chk({flag_sat, result_data}, 25'h0);
      nres++;
      slow <= 1'h0;
      repeat (8) @(posedge clk);
      chk(25'(taken), 25'(nres));
      wrap_up();
   end
endmodule : tb_top
